// ==== rtl/gdf_driver.sv ====
`timescale 1ns/10ps
module gdf_driver
    import gdf_pkg::*;
#(
    parameter int unsigned BLOCK_N   = BLOCK_CYC,
    parameter int unsigned FAIL_N    = FAIL_SHOW_CYC,
    parameter int unsigned CLEAR_N   = ERR_CLEAR_CYC,
    parameter int unsigned XDELAY_N  = XOFF_DELAY_CYC,
    parameter int unsigned XHOLD_N   = XOFF_HOLD_CYC,
    parameter int unsigned POWERUP_N = POWERUP_CYC
)
(
    // Clock and reset
    input  wire logic     i_clk_sys,
    input  wire logic     i_rst,
    // Optical drive inputs, high means light on
    input  wire logic     i_first_optical_drive_input,
    input  wire logic     i_second_optical_drive_input,
    // Fault detectors per channel
    input  wire gdf_det_s i_det_a,
    input  wire gdf_det_s i_det_b,
    // Gate commands, high on, low means negative gate drive
    output logic          o_gate_a,
    output logic          o_gate_b,
    // Optical status outputs, high means light on
    output logic          o_status_a,
    output logic          o_status_b
);
    logic [NUM_CH-1:0]      drive;
    logic [NUM_CH-1:0]      drive_q_r;
    logic [NUM_CH-1:0]      edge_det;
    logic [NUM_CH-1:0]      gate;
    logic [NUM_CH-1:0]      fail_show;
    logic [NUM_CH-1:0]      stored;
    logic [NUM_CH-1:0]      blocked;
    logic [NUM_CH-1:0]      force_off_r;
    logic [NUM_CH-1:0]      status_nxt;
    logic [NUM_CH-1:0]      status_r;
    logic [ACK_W-1:0]       ack_cnt_r [NUM_CH];
    logic [CNT_W-1:0]       x_cnt_r   [NUM_CH];
    logic [NUM_CH-1:0]      x_hold_r;
    logic [CNT_W-1:0]       pwr_cnt_r;
    gdf_det_s               det [NUM_CH];

    // Direct mode: each input drives its own channel
    assign drive    = {i_second_optical_drive_input,
                       i_first_optical_drive_input};
    assign det[0]   = i_det_a;
    assign det[1]   = i_det_b;
    assign edge_det = drive ^ drive_q_r;

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
            drive_q_r <= '0;
        else
            drive_q_r <= drive;
    end

    // Power-up failure indication
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
            pwr_cnt_r <= CNT_W'(POWERUP_N);
        else if (pwr_cnt_r != '0)
            pwr_cnt_r <= pwr_cnt_r - 1'b1;
    end

    generate
        for (genvar c = 0; c < NUM_CH; c++)
        begin : g_ch
            localparam int O = 1 - c;

            gdf_channel #(
                .BLOCK_N (BLOCK_N),
                .FAIL_N  (FAIL_N),
                .CLEAR_N (CLEAR_N)
            ) u_ch (
                .i_clk_sys    (i_clk_sys),
                .i_rst        (i_rst),
                .i_drive      (drive[c]),
                .i_drive_edge (edge_det[c]),
                .i_det        (det[c]),
                .i_force_off  (force_off_r[c]),
                .o_gate_on    (gate[c]),
                .o_fail_show  (fail_show[c]),
                .o_stored     (stored[c]),
                .o_blocked    (blocked[c])
            );

            // Edge acknowledge pulse, ignored while the channel is blocked
            always_ff @(posedge i_clk_sys)
            begin
                if (i_rst)
                    ack_cnt_r[c] <= '0;
                else if (edge_det[c] && !blocked[c])
                    ack_cnt_r[c] <= ACK_W'(ACK_PULSE_CYC);
                else if (ack_cnt_r[c] != '0)
                    ack_cnt_r[c] <= ack_cnt_r[c] - 1'b1;
            end

            // Cross-channel shutdown: delay after the faulted edge, then hold
            always_ff @(posedge i_clk_sys)
            begin
                if (i_rst)
                begin
                    x_cnt_r[c]     <= '0;
                    x_hold_r[c]    <= 1'b0;
                    force_off_r[c] <= 1'b0;
                end
                else if (blocked[O] && !stored[O] && edge_det[O]
                         && x_cnt_r[c] == '0)
                begin
                    x_cnt_r[c]  <= CNT_W'(XDELAY_N);
                    x_hold_r[c] <= 1'b0;
                end
                else if (x_cnt_r[c] == CNT_W'(1) && !x_hold_r[c])
                begin
                    force_off_r[c] <= 1'b1;
                    x_hold_r[c]    <= 1'b1;
                    x_cnt_r[c]     <= CNT_W'(XHOLD_N);
                end
                else if (x_cnt_r[c] == CNT_W'(1) && x_hold_r[c])
                begin
                    force_off_r[c] <= 1'b0;
                    x_hold_r[c]    <= 1'b0;
                    x_cnt_r[c]     <= '0;
                end
                else if (x_cnt_r[c] != '0)
                    x_cnt_r[c] <= x_cnt_r[c] - 1'b1;
            end

            // Light off while a stored failure is shown, on undervoltage, ack pulse or power-up time
            assign status_nxt[c] = !(fail_show[c] || ack_cnt_r[c] != '0
                                     || pwr_cnt_r != '0
                                     || det[c].uvlo);
        end
    endgenerate

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
            status_r <= '0;
        else
            status_r <= status_nxt;
    end

    // Gate from channel flop, re-registered for clean top outputs
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            o_gate_a <= 1'b0;
            o_gate_b <= 1'b0;
        end
        else
        begin
            o_gate_a <= gate[0] && !force_off_r[0];
            o_gate_b <= gate[1] && !force_off_r[1];
        end
    end

    assign o_status_a = status_r[0];
    assign o_status_b = status_r[1];

    sequence s_edge_a;
        edge_det[0] && !blocked[0];
    endsequence

    chk_ack_pulse_off: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        s_edge_a |=> ##1 !o_status_a)
        else $error("edge not acknowledged");

    chk_uvlo_gate_off: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_det_a.uvlo |=> ##1 !o_gate_a)
        else $error("gate on during undervoltage");

    chk_uvlo_status: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_det_b.uvlo |=> !o_status_b)
        else $error("undervoltage not reported");

    chk_powerup_fail: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        pwr_cnt_r != '0 |=> !o_status_a && !o_status_b)
        else $error("power-up fault not shown");

    chk_force_gate: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        force_off_r[1] |=> !o_gate_b)
        else $error("forced channel still on");

    chk_fail_shown: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        fail_show[0] |=> !o_status_a)
        else $error("failure not shown");

    chk_direct_on: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        gate[0] && !force_off_r[0] |=> o_gate_a)
        else $error("gate not following input");

    chk_status_ok: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        status_nxt[0] |=> o_status_a)
        else $error("status dark while healthy");

    sequence s_edge_b;
        edge_det[1] && !blocked[1];
    endsequence

    // Cross-channel timer reaching the end of its delay or hold phase
    sequence s_xarm_a;
        x_cnt_r[0] == CNT_W'(1) && !x_hold_r[0];
    endsequence

    sequence s_xarm_b;
        x_cnt_r[1] == CNT_W'(1) && !x_hold_r[1];
    endsequence

    sequence s_xend_a;
        x_cnt_r[0] == CNT_W'(1) && x_hold_r[0];
    endsequence

    sequence s_xend_b;
        x_cnt_r[1] == CNT_W'(1) && x_hold_r[1];
    endsequence

    chk_ack_pulse_b: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        s_edge_b |=> ##1 !o_status_b)
        else $error("edge not acknowledged on b");

    chk_uvlo_gate_b: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_det_b.uvlo |=> ##1 !o_gate_b)
        else $error("gate b on during undervoltage");

    chk_uvlo_stat_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_det_a.uvlo |=> !o_status_a)
        else $error("undervoltage on a not reported");

    chk_force_gate_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        force_off_r[0] |=> !o_gate_a)
        else $error("forced channel a still on");

    chk_fail_shown_b: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        fail_show[1] |=> !o_status_b)
        else $error("failure on b not shown");

    chk_direct_on_b: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        gate[1] && !force_off_r[1] |=> o_gate_b)
        else $error("gate b not following input");

    chk_status_ok_b: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        status_nxt[1] |=> o_status_b)
        else $error("status b dark while healthy");

    chk_block_off_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        blocked[0] |=> ##1 !o_gate_a)
        else $error("gate a on while blocked");

    chk_block_off_b: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        blocked[1] |=> ##1 !o_gate_b)
        else $error("gate b on while blocked");

    chk_no_ack_block: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        edge_det[0] && blocked[0] && ack_cnt_r[0] == '0
        |=> ack_cnt_r[0] == '0)
        else $error("edge acknowledged while blocked");

    chk_xoff_arm_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        s_xarm_a |=> force_off_r[0])
        else $error("channel a not forced off");

    chk_xoff_arm_b: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        s_xarm_b |=> force_off_r[1])
        else $error("channel b not forced off");

    chk_xoff_end_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        s_xend_a |=> !force_off_r[0])
        else $error("channel a not re-enabled");

    chk_xoff_end_b: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        s_xend_b |=> !force_off_r[1])
        else $error("channel b not re-enabled");

    chk_pwr_count: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        pwr_cnt_r != '0 |=> pwr_cnt_r < $past(pwr_cnt_r))
        else $error("power-up counter stalled");

endmodule

// ==== inc/gdf_pkg.sv ====
package gdf_pkg;

    localparam int unsigned CLK_HZ         = 25_000_000;
    localparam int unsigned NUM_CH         = 2;

    // Durations as printed
    localparam int unsigned ACK_PULSE_NS   = 1000;
    localparam int unsigned BLOCK_MS       = 1000;
    localparam int unsigned FAIL_SHOW_MS   = 12;
    localparam int unsigned XOFF_DELAY_MS  = 8;
    localparam int unsigned XOFF_HOLD_MS   = 4;
    localparam int unsigned POWERUP_MS     = 8;
    localparam int unsigned ERR_CLEAR_US   = 3500;
    localparam int unsigned RESP_TIME_NS   = 4000;

    // Cycle counts derived from the clock rate
    localparam int unsigned ACK_PULSE_CYC  =
        (ACK_PULSE_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam int unsigned RESP_TIME_CYC  =
        (RESP_TIME_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam int unsigned BLOCK_CYC      = BLOCK_MS * (CLK_HZ / 1000);
    localparam int unsigned FAIL_SHOW_CYC  = FAIL_SHOW_MS * (CLK_HZ / 1000);
    localparam int unsigned XOFF_DELAY_CYC = XOFF_DELAY_MS * (CLK_HZ / 1000);
    localparam int unsigned XOFF_HOLD_CYC  = XOFF_HOLD_MS * (CLK_HZ / 1000);
    localparam int unsigned POWERUP_CYC    = POWERUP_MS * (CLK_HZ / 1000);
    localparam int unsigned ERR_CLEAR_CYC  = ERR_CLEAR_US * (CLK_HZ / 1_000_000);

    localparam int unsigned CNT_W          = 25;
    localparam int unsigned ACK_W          = 8;

    typedef enum logic [1:0] {
        GDF_RUN,
        GDF_BLOCK,
        GDF_STORED
    } gdf_state_e;

    typedef struct packed {
        logic desat;
        logic uvlo;
    } gdf_det_s;

endpackage

// ==== rtl/gdf_channel.sv ====
`timescale 1ns/10ps
module gdf_channel
    import gdf_pkg::*;
#(
    parameter int unsigned BLOCK_N = BLOCK_CYC,
    parameter int unsigned FAIL_N  = FAIL_SHOW_CYC,
    parameter int unsigned CLEAR_N = ERR_CLEAR_CYC
)
(
    // Clock and reset
    input  wire logic     i_clk_sys,
    input  wire logic     i_rst,
    // Drive and detectors
    input  wire logic     i_drive,
    input  wire logic     i_drive_edge,
    input  wire gdf_det_s i_det,
    input  wire logic     i_force_off,
    // Results
    output logic          o_gate_on,
    output logic          o_fail_show,
    output logic          o_stored,
    output logic          o_blocked
);
    gdf_state_e             state_r;
    logic [CNT_W-1:0]       blk_cnt_r;
    logic [CNT_W-1:0]       clr_cnt_r;
    logic [CNT_W-1:0]       show_cnt_r;
    logic [ACK_W-1:0]       resp_cnt_r;
    logic                   fault_now;
    logic                   desat_q;

    // Saturation check is blanked until the response time after turn-on
    assign desat_q   = i_det.desat && (resp_cnt_r == '0) && o_gate_on;
    assign fault_now = desat_q || i_det.uvlo;

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
            resp_cnt_r <= '0;
        else if (!o_gate_on && i_drive && state_r == GDF_RUN)
            resp_cnt_r <= ACK_W'(RESP_TIME_CYC);
        else if (resp_cnt_r != '0)
            resp_cnt_r <= resp_cnt_r - 1'b1;
    end

    // Fault sequencing: block, then store on next drive edge
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            state_r   <= GDF_RUN;
            blk_cnt_r <= '0;
            clr_cnt_r <= '0;
        end
        else
        begin
            if (blk_cnt_r != '0)
                blk_cnt_r <= blk_cnt_r - 1'b1;
            if (clr_cnt_r != '0)
                clr_cnt_r <= clr_cnt_r - 1'b1;
            case (state_r)
                GDF_RUN:
                begin
                    if (fault_now)
                    begin
                        state_r   <= GDF_BLOCK;
                        blk_cnt_r <= CNT_W'(BLOCK_N);
                    end
                end
                GDF_BLOCK:
                begin
                    if (i_drive_edge)
                    begin
                        state_r   <= GDF_STORED;
                        clr_cnt_r <= CNT_W'(CLEAR_N);
                    end
                    else if (blk_cnt_r == '0 && !i_det.uvlo)
                        state_r <= GDF_RUN;
                end
                GDF_STORED:
                begin
                    if (clr_cnt_r == '0 && blk_cnt_r == '0 && !i_det.uvlo)
                        state_r <= GDF_RUN;
                end
                default:
                    state_r <= GDF_RUN;
            endcase
        end
    end

    // Failure shown for a fixed time from the storing edge
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
            show_cnt_r <= '0;
        else if (state_r == GDF_BLOCK && i_drive_edge)
            show_cnt_r <= CNT_W'(FAIL_N);
        else if (show_cnt_r != '0)
            show_cnt_r <= show_cnt_r - 1'b1;
    end

    // Gate follows drive only when running and not forced off
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
            o_gate_on <= 1'b0;
        else
            o_gate_on <= i_drive && state_r == GDF_RUN && !fault_now
                         && !i_force_off;
    end

    assign o_fail_show = (show_cnt_r != '0);
    assign o_stored    = (state_r == GDF_STORED);
    assign o_blocked   = (state_r != GDF_RUN);

    chk_gate_off_blocked: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        state_r != GDF_RUN |=> !o_gate_on)
        else $error("gate on while blocked");

    chk_store_on_edge: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        state_r == GDF_BLOCK && i_drive_edge |=> state_r == GDF_STORED)
        else $error("error not stored on drive edge");

endmodule

// ==== dv/gdf_host_model.sv ====
`timescale 1ns/10ps
module gdf_host_model
    import gdf_pkg::*;
#(
    parameter int unsigned ACK_LIM = ACK_PULSE_CYC + 4
)
(
    // Clock and reset
    input  wire logic i_clk_sys,
    input  wire logic i_rst,
    // Requests from the bench
    input  wire logic i_req_a,
    input  wire logic i_req_b,
    input  wire logic i_shut_en,
    // Status lines from the driver
    input  wire logic i_status_a,
    input  wire logic i_status_b,
    // Optical drive lines
    output logic      o_drive_a,
    output logic      o_drive_b
);
    logic [7:0] dark_r;
    logic       shut_r;

    // Dark longer than an acknowledge pulse means a fault
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst || (i_status_a && i_status_b))
            dark_r <= 8'h00;
        else if (dark_r != 8'hFF)
            dark_r <= dark_r + 8'h01;
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst || !i_shut_en)
            shut_r <= 1'b0;
        else if ({24'h000000, dark_r} > ACK_LIM)
            shut_r <= 1'b1;
    end

    // Light on asks for the switch on
    assign o_drive_a = i_req_a && !shut_r;
    assign o_drive_b = i_req_b && !shut_r;
endmodule

// ==== dv/tb_top.sv ====
`timescale 1ns/10ps
module tb_top
    import gdf_pkg::*;
();
    localparam int BLK = 200;
    localparam int FAL = 60;
    localparam int CLR = 40;
    localparam int XD  = 30;
    localparam int XH  = 20;
    localparam int PWR = 50;

    logic     clk;
    logic     rst;
    logic     req_a;
    logic     req_b;
    logic     shut_en;
    gdf_det_s det_a;
    gdf_det_s det_b;
    logic     drive_a;
    logic     drive_b;
    logic     gate_a;
    logic     gate_b;
    logic     status_a;
    logic     status_b;
    int       err_count;
    int       checks;
    int       tc;

    gdf_host_model gdf_host_model_i (
        .i_clk_sys  (clk),
        .i_rst      (rst),
        .i_req_a    (req_a),
        .i_req_b    (req_b),
        .i_shut_en  (shut_en),
        .i_status_a (status_a),
        .i_status_b (status_b),
        .o_drive_a  (drive_a),
        .o_drive_b  (drive_b)
    );

    gdf_driver #(
        .BLOCK_N   (BLK),
        .FAIL_N    (FAL),
        .CLEAR_N   (CLR),
        .XDELAY_N  (XD),
        .XHOLD_N   (XH),
        .POWERUP_N (PWR)
    ) gdf_driver_i (
        .i_clk_sys                    (clk),
        .i_rst                        (rst),
        .i_first_optical_drive_input  (drive_a),
        .i_second_optical_drive_input (drive_b),
        .i_det_a                      (det_a),
        .i_det_b                      (det_b),
        .o_gate_a                     (gate_a),
        .o_gate_b                     (gate_b),
        .o_status_a                   (status_a),
        .o_status_b                   (status_b)
    );

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wait_to(input int n);
        step(n - tc);
        tc = n;
    endtask

    task automatic chk(input logic got, input logic exp);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("errors=%0d checks=%0d", err_count, checks);
        if (err_count == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    function automatic logic gate_of(input int ch);
        return (ch == 0) ? gate_a : gate_b;
    endfunction

    function automatic logic stat_of(input int ch);
        return (ch == 0) ? status_a : status_b;
    endfunction

    task automatic t_powerup();
        step(PWR - 2);
        chk(status_a, 1'b0);
        chk(status_b, 1'b0);
        step(4);
        chk(status_a, 1'b1);
        chk(status_b, 1'b1);
    endtask

    // Both edges on one channel, each acknowledged by a dark pulse
    task automatic t_ack(input int ch);
        logic v;
        for (int k = 0; k < 2; k++)
        begin
            v = (k == 0);
            if (ch == 0)
                req_a = v;
            else
                req_b = v;
            step(1);
            chk(gate_of(ch), !v);
            step(1);
            chk(gate_of(ch), v);
            chk(stat_of(ch), 1'b0);
            step(ACK_PULSE_CYC - 1);
            chk(stat_of(ch), 1'b0);
            step(1);
            chk(stat_of(ch), 1'b1);
            chk(stat_of(1 - ch), 1'b1);
            step(5);
        end
    endtask

    task automatic t_blank();
        req_a = 1'b1;
        step(5);
        det_a.desat = 1'b1;
        step(40);
        chk(gate_a, 1'b1);
        det_a.desat = 1'b0;
        step(80);
        chk(gate_a, 1'b1);
    endtask

    // Desat on A, then edges while blocked and cross-channel shutdown
    task automatic t_desat();
        req_b = 1'b1;
        step(30);
        det_a.desat = 1'b1;
        step(3);
        chk(gate_a, 1'b0);
        det_a.desat = 1'b0;
        step(1);
        chk(status_a, 1'b1);
        tc = 0;
        req_a = 1'b0;
        wait_to(3);
        chk(status_a, 1'b0);
        req_a = 1'b1;
        wait_to(6);
        chk(gate_a, 1'b0);
        wait_to(XD - 2);
        chk(gate_b, 1'b1);
        wait_to(XD + 4);
        chk(gate_b, 1'b0);
        wait_to(XD + XH - 2);
        chk(gate_b, 1'b0);
        wait_to(XD + XH + 5);
        chk(gate_b, 1'b1);
        wait_to(FAL - 2);
        chk(status_a, 1'b0);
        wait_to(FAL + 4);
        chk(status_a, 1'b1);
        wait_to(BLK - 7);
        chk(gate_a, 1'b0);
        wait_to(BLK + 2);
        req_a = 1'b0;
        wait_to(BLK + 5);
        req_a = 1'b1;
        wait_to(BLK + 8);
        chk(gate_a, 1'b1);
        chk(status_a, 1'b0);
    endtask

    // Undervoltage on B with the host shutting both channels down
    task automatic t_uvlo();
        step(40);
        shut_en = 1'b1;
        det_b.uvlo = 1'b1;
        tc = 0;
        wait_to(4);
        chk(gate_b, 1'b0);
        chk(status_b, 1'b0);
        chk(gate_a, 1'b1);
        wait_to(45);
        chk(drive_a, 1'b0);
        chk(drive_b, 1'b0);
        chk(gate_a, 1'b0);
        det_b.uvlo = 1'b0;
        wait_to(50);
        shut_en = 1'b0;
        req_a = 1'b0;
        req_b = 1'b0;
        wait_to(BLK + FAL + XD + XH + 40);
        chk(status_a, 1'b1);
        chk(status_b, 1'b1);
        req_b = 1'b1;
        step(2);
        chk(gate_b, 1'b1);
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        err_count++;
        end_sim();
    end

    initial
    begin
        rst = 1'b1;
        req_a = 1'b0;
        req_b = 1'b0;
        shut_en = 1'b0;
        det_a = '0;
        det_b = '0;
        err_count = 0;
        checks = 0;
        tc = 0;
        repeat (3) @(posedge clk);
        #1;
        rst = 1'b0;
        t_powerup();
        t_ack(0);
        t_ack(1);
        t_blank();
        t_desat();
        t_uvlo();
        end_sim();
    end
endmodule
